/* File: rtl/sdl_pkg.sv */
// Constants shared by the serial converter front end and its register bus slave.
// Assumes one 50 MHz system clock; all pins of the serial port are asynchronous to it.
// Function
// [R1] Take part only while device select low.
// [R2] Frame strobe fall starts word, MSB first.
// [R3] Latch word after sixteen bits or strobe rise.
// [R4] Update on next clock rise or strobe rise.
// [R5] Reset clears converter latch and control settings.
// [R6] Latch holds unsigned ten-bit linear code.
// [R7] Four-wire or three-wire with select tied low.
// [R8] Host orders select, strobe, then clock edges.
// [R9] Host keeps select low until update done.
// [R10] Word layout: speed, power-down, code, zeros.
// [R11] Power-down bit disables all amplifiers.
// [R12] Select high ignores all serial inputs.
package sdl_pkg;
   // ------------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------------
   localparam int unsigned WORD_BITS = 16;
   localparam int unsigned CODE_BITS = 10;
   localparam int unsigned SPEED_POS = 14;
   localparam int unsigned PWRDN_POS = 13;
   localparam int unsigned CODE_MSB = 11;
   localparam int unsigned CODE_LSB = 2;
   localparam logic [4:0] LAST_COUNT = 5'h10;
   // ------------------------------------------------------------------
   // Register map, byte addresses
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_CODE = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [3:0] ADDR_SHIFT = 4'hc;
   localparam int unsigned CTRL_SPEED_BIT = 0;
   localparam int unsigned CTRL_PWRDN_BIT = 1;
   localparam int unsigned STAT_AMP_OFF_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 1;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [7:0] RESET_COUNT = 8'h00;
endpackage

/* File: rtl/sdl_sync.sv */
// Two-stage synchroniser for the serial port pins.
// Assumes the pins are asynchronous to clk_i.
module sdl_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Pins
   input wire logic [3:0] async_i,
   output logic [3:0] sync_o
);
   logic [3:0] meta;

   // The first stage is read only by the second, to contain metastability.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // Reset to the idle pin levels: deselected, strobe high, clock and data low.
         // This keeps the edge detectors from seeing a false edge after reset.
         meta <= 4'hc;
         sync_o <= 4'hc;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule

/* File: rtl/sdl_serial_dac_input_and_latch.sv */
// Serial input shifter and converter latch with a classic Wishbone slave.
// Assumes the host keeps shift clock half-periods well above two system clocks.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
module sdl_serial_dac_input_and_latch (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Serial port pins
   input wire logic device_select_n_i,
   input wire logic frame_strobe_n_i,
   input wire logic shift_clock_i,
   input wire logic serial_data_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Converter side
   output logic [9:0] dac_code_o,
   output logic settle_speed_select_o,
   output logic power_down_control_o,
   output logic amp_disable_o,
   output logic latch_update_o
);
   // ------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------
   logic [3:0] pins;
   logic sel_n, fs_n, sck, sdi;
   logic fs_n_d, sck_d;
   logic fs_fall, fs_rise, sck_fall, sck_rise;

   sdl_sync u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i({device_select_n_i, frame_strobe_n_i, shift_clock_i, serial_data_i}),
      .sync_o(pins)
   );

   assign sel_n = pins[3];
   assign fs_n = pins[2];
   assign sck = pins[1];
   assign sdi = pins[0];

   // Edge history, taken from synchronised copies only.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fs_n_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         fs_n_d <= fs_n;
         sck_d <= sck;
      end
   end

   // With select high every edge is masked, so shared lines cannot disturb us.
   assign fs_fall = !sel_n && fs_n_d && !fs_n; // [R1] [R12]
   assign fs_rise = !sel_n && !fs_n_d && fs_n; // [R12]
   assign sck_fall = !sel_n && sck_d && !sck; // [R7]
   assign sck_rise = !sel_n && !sck_d && sck;

   // ------------------------------------------------------------------
   // Frame state and shifter
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {SDL_IDLE, SDL_SHIFT, SDL_WAIT_RISE} sdl_state_t;
   sdl_state_t state;
   logic [15:0] shift_reg;
   logic [4:0] bit_count;
   logic do_update;

   // A word is finished by the first rising clock after sixteen bits, or by
   // the strobe rising early; whichever comes first wins.
   assign do_update = (state == SDL_WAIT_RISE && (sck_rise || fs_rise)) ||
                      (state == SDL_SHIFT && fs_rise); // [R3] [R4]

   // Frame sequencing.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= SDL_IDLE;
      end else begin
         unique case (state)
            SDL_IDLE: begin
               if (fs_fall) begin
                  state <= SDL_SHIFT; // [R2]
               end
            end
            SDL_SHIFT: begin
               if (fs_rise) begin
                  state <= SDL_IDLE;
               end else if (sck_fall && bit_count == LAST_COUNT_M1()) begin
                  state <= SDL_WAIT_RISE;
               end
            end
            SDL_WAIT_RISE: begin
               if (do_update) begin
                  state <= SDL_IDLE;
               end
            end
         endcase
      end
   end

   function automatic logic [4:0] LAST_COUNT_M1();
      return sdl_pkg::LAST_COUNT - 5'h01;
   endfunction

   // Bits enter at the bottom so the first one ends at the top.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shift_reg <= sdl_pkg::RESET_WORD[15:0];
         bit_count <= sdl_pkg::RESET_COUNT[4:0];
      end else if (fs_fall) begin
         bit_count <= sdl_pkg::RESET_COUNT[4:0];
      end else if (state == SDL_SHIFT && sck_fall) begin
         shift_reg <= {shift_reg[14:0], sdi}; // [R2]
         bit_count <= bit_count + 5'h01;
      end
   end

   // ------------------------------------------------------------------
   // Converter latch
   // ------------------------------------------------------------------
   // An early strobe rise latches the shifter as it stands, short words included.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dac_code_o <= sdl_pkg::RESET_WORD[9:0]; // [R5]
         settle_speed_select_o <= 1'b0; // [R5]
         power_down_control_o <= 1'b0; // [R5]
      end else if (do_update) begin
         dac_code_o <= shift_reg[sdl_pkg::CODE_MSB:sdl_pkg::CODE_LSB]; // [R6] [R10]
         settle_speed_select_o <= shift_reg[sdl_pkg::SPEED_POS]; // [R10]
         power_down_control_o <= shift_reg[sdl_pkg::PWRDN_POS]; // [R10]
      end
   end

   // Amplifier disable follows the latched power-down bit.
   assign amp_disable_o = power_down_control_o; // [R11]

   // One-cycle marker of each latch update.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         latch_update_o <= 1'b0;
      end else begin
         latch_update_o <= do_update;
      end
   end

   // ------------------------------------------------------------------
   // Wishbone slave, read only, one wait state
   // ------------------------------------------------------------------
   // Latch contents belong to the serial port; writes are acknowledged and dropped.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= sdl_pkg::RESET_WORD;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= sdl_pkg::RESET_WORD;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            unique case (wb_adr_i)
               sdl_pkg::ADDR_CODE: wb_dat_o <= {22'h000000, dac_code_o};
               sdl_pkg::ADDR_CTRL: wb_dat_o <= {30'h00000000, power_down_control_o,
                                                settle_speed_select_o};
               sdl_pkg::ADDR_STAT: wb_dat_o <= {30'h00000000, state != SDL_IDLE,
                                                amp_disable_o};
               sdl_pkg::ADDR_SHIFT: wb_dat_o <= {16'h0000, shift_reg};
               default: wb_dat_o <= sdl_pkg::RESET_WORD;
            endcase
         end
      end
   end
endmodule

/* File: verification/sdl_asserts.sv */
// Checker for the converter front end, bound to its top module.
// Assumes one clock domain and the registered one-cycle bus answer.
module sdl_asserts (
   // Watched ports
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic device_select_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [9:0] dac_code_o,
   input wire logic power_down_control_o,
   input wire logic amp_disable_o,
   input wire logic latch_update_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // A bus request not yet answered; the reply must follow in one cycle.
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   property p_amp; amp_disable_o == power_down_control_o; endproperty
   a_amp: assert property (p_amp) else $error("amplifier disable differs");
   property p_chg; $changed(dac_code_o) |-> latch_update_o; endproperty
   a_chg: assert property (p_chg) else $error("code moved without update");
   property p_sel; device_select_n_i [*8] |=> !latch_update_o; endproperty
   a_sel: assert property (p_sel) else $error("update while deselected");
   property p_upd; latch_update_o |=> !latch_update_o; endproperty
   a_upd: assert property (p_upd) else $error("update pulse too long");
   property p_ack; s_req |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bus answer late");
   property p_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_one: assert property (p_one) else $error("bus answer too long");
   property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_code;
      wb_ack_o && !wb_we_i && wb_adr_i == sdl_pkg::ADDR_CODE |->
         wb_dat_o == {22'h0, $past(dac_code_o)};
   endproperty
   a_code: assert property (p_code) else $error("code read differs");
endmodule

bind sdl_serial_dac_input_and_latch sdl_asserts chk_u (.*);

/* File: verification/sdl_host_model.sv */
// Host serial port model for the converter's four serial pins.
// Assumes a 20 ns bench clock; shift clock half period is four cycles.
module sdl_host_model (
   // Clock
   input wire logic clk_i,
   // Serial pins
   output logic device_select_n_o,
   output logic frame_strobe_n_o,
   output logic shift_clock_o,
   output logic serial_data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // When set, select stays low after a frame, as with the select pin tied low.
   bit three_wire = 1'b0;
   // Idle pins: deselected, strobe high, clock parked low between frames.
   initial begin
      device_select_n_o = 1'b1;
      frame_strobe_n_o = 1'b1;
      shift_clock_o = 1'b0;
      serial_data_o = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Sends the top nbits of w; sel low leaves the device out of the frame.
   task automatic send(input logic [15:0] w, input int nbits, input logic sel);
      device_select_n_o <= !sel;
      hold(4);
      frame_strobe_n_o <= 1'b0;
      hold(4);
      for (int i = 0; i < nbits; i++) begin
         shift_clock_o <= 1'b1;
         serial_data_o <= w[15 - i];
         hold(4);
         shift_clock_o <= 1'b0;
         hold(4);
      end
      shift_clock_o <= (nbits == 16);
      hold(4);
      shift_clock_o <= 1'b0;
      frame_strobe_n_o <= 1'b1;
      hold(8);
      device_select_n_o <= !(sel && three_wire);
      serial_data_o <= !serial_data_o; // A released line keeps no level.
      hold(8);
   endtask
endmodule

/* File: verification/sdl_serial_dac_input_and_latch_tb_top.sv */
// Self-checking bench for the converter front end.
// Assumes the host model and checker are compiled before it.
module sdl_serial_dac_input_and_latch_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sel_n, fs_n, sck, sdi, wb_ack_o, settle_speed_select, pd, amp, upd;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [9:0] dac_code_o;
   int n_mismatch = 0;
   int compares = 0;
   int n_upd = 0;
   always #10 clk_i = ~clk_i;
   // Counts latch update markers, so the pulse output is checked too.
   always @(posedge clk_i) if (upd === 1'b1) n_upd++;
   sdl_host_model host_u (.clk_i(clk_i), .device_select_n_o(sel_n),
      .frame_strobe_n_o(fs_n), .shift_clock_o(sck), .serial_data_o(sdi));
   sdl_serial_dac_input_and_latch dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
      .device_select_n_i(sel_n), .frame_strobe_n_i(fs_n), .shift_clock_i(sck),
      .serial_data_i(sdi), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .dac_code_o(dac_code_o), .settle_speed_select_o(settle_speed_select),
      .power_down_control_o(pd), .amp_disable_o(amp), .latch_update_o(upd));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One classic cycle; e is write data or the expected read data.
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] e);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= e;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
      if (!we) check(wb_dat_o, e);
      if (n >= 50) n_mismatch++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog: the tests need about 800 cycles.
   initial begin
      repeat (5000) @(posedge clk_i);
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h0);
      wb(1'b0, sdl_pkg::ADDR_CTRL, 32'h0);
      $display("test reset done");
      host_u.send(16'hdffc, 16, 1'b1);
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h3ff);
      wb(1'b0, sdl_pkg::ADDR_CTRL, 32'h1);
      host_u.send(16'h2554, 16, 1'b1);
      wb(1'b0, sdl_pkg::ADDR_CTRL, 32'h2);
      wb(1'b0, sdl_pkg::ADDR_STAT, 32'h1);
      check({22'h0, dac_code_o}, 32'h155);
      check({30'h0, pd, settle_speed_select}, 32'h2);
      check({31'h0, amp}, 32'h1);
      $display("test full words done");
      host_u.send(16'habc0, 12, 1'b1);
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h2af);
      host_u.send(16'h4004, 16, 1'b0);
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h2af);
      $display("test early and deselected done");
      wb(1'b1, sdl_pkg::ADDR_CODE, 32'h1);
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h2af);
      wb(1'b0, 4'h1, 32'h0);
      $display("test bus done");
      host_u.three_wire = 1'b1;
      host_u.send(16'h6010, 16, 1'b1);
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h4);
      wb(1'b0, sdl_pkg::ADDR_CTRL, 32'h3);
      check({31'h0, amp}, 32'h1);
      $display("test three wire done");
      nrst_i <= 1'b0;
      @(posedge clk_i);
      nrst_i <= 1'b1;
      wb(1'b0, sdl_pkg::ADDR_CODE, 32'h0);
      wb(1'b0, sdl_pkg::ADDR_CTRL, 32'h0);
      check({31'h0, amp}, 32'h0);
      check(n_upd, 32'h4);
      $display("test second reset done");
      report_and_stop;
   end
endmodule
